// ---- hdl/rhs_defines.svh ----
/*
 * Command codes, bit positions and reset values of the root hub status block.
 * Assumes it is included by its bare name wherever these constants are needed.
 */
`ifndef RHS_DEFINES_SVH
`define RHS_DEFINES_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define RHS_CMD_HUB_RD 8'h14
`define RHS_CMD_HUB_WR 8'h94
`define RHS_CMD_P1_RD 8'h15
`define RHS_CMD_P1_WR 8'h95
`define RHS_CMD_P2_RD 8'h16
`define RHS_CMD_P2_WR 8'h96

// ----------------------------------------
// root_hub_state bit positions
// ----------------------------------------
`define RHS_HUB_CLEAR_WAKE_BIT 31
`define RHS_HUB_OC_CHANGE_BIT 17
`define RHS_HUB_SET_POWER_BIT 16
`define RHS_HUB_WAKE_BIT 15
`define RHS_HUB_OC_BIT 1
`define RHS_HUB_CLEAR_POWER_BIT 0

// ----------------------------------------
// port_state_register bit positions
// ----------------------------------------
`define RHS_PORT_CONNECTED_BIT 0
`define RHS_PORT_ENABLE_BIT 1
`define RHS_PORT_POWER_BIT 8
`define RHS_PORT_CLEAR_POWER_BIT 9
`define RHS_PORT_CONNECT_CHANGE_BIT 16
`define RHS_PORT_ENABLE_CHANGE_BIT 17

// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define RHS_NUM_PORTS 2
`define RHS_HUB_RESET 32'h0000_0000
`define RHS_PORT_RESET 32'h0000_0000

`endif

// ---- hdl/rhs_pkg.sv ----
/*
 * Types and the sticky-flag helper of the root hub status block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rhs_pkg;

    // ----------------------------------------
    // state of the hub-wide part
    // ----------------------------------------
    typedef struct packed {
        logic oc_meta;
        logic oc_sync;
        logic oc_flag;
        logic oc_change;
        logic wake_en;
        logic resume;
        logic rvalid;
        logic [31:0] rdata;
    } rhs_hub_t;

    // ----------------------------------------
    // state of one downstream port
    // ----------------------------------------
    typedef struct packed {
        logic conn_meta;
        logic conn_sync;
        logic conn_last;
        logic connected;
        logic enabled;
        logic powered;
        logic conn_change;
        logic enable_change;
        logic pend;
        logic [31:0] pend_data;
    } rhs_port_t;

    // hardware set wins over software clear
    function automatic logic rhs_sticky(input logic flag, input logic set, input logic clr);
        rhs_sticky = set | (flag & ~clr);
    endfunction

endpackage

// ---- hdl/rhs_port_reg.sv ----
/*
 * One port status register: connect tracking, enable, power and change flags,
 * with writes held back while a bus transaction is in progress.
 * Assumes the connect pin is asynchronous and the busy flag is on CLK_I.
 */
`timescale 1ns/10ps
`include "rhs_defines.svh"

module rhs_port_reg (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic conn_pin_i,
    input wire logic xact_busy_i,
    input wire logic wr_i,
    input wire logic [31:0] wdata_i,
    input wire logic global_on_i,
    input wire logic global_off_i,
    input wire logic port_cmd_en_i,
    output logic [31:0] rdata_o,
    output logic power_o,
    output logic conn_change_o
);

    rhs_pkg::rhs_port_t r_reg;
    rhs_pkg::rhs_port_t r_next;

    logic conn_evt;
    logic apply;
    logic [31:0] wv;
    logic force_csc;
    logic hw_disable;
    logic pwr_on;
    logic pwr_off;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.conn_meta = conn_pin_i;
        r_next.conn_sync = r_reg.conn_meta;
        r_next.conn_last = r_reg.conn_sync;
        conn_evt = r_reg.conn_sync ^ r_reg.conn_last;
        r_next.connected = r_reg.conn_sync;
        // held write lands once the transaction is over
        apply = r_reg.pend & ~xact_busy_i;
        wv = apply ? r_reg.pend_data : 32'h0000_0000;
        if (apply) begin
            r_next.pend = 1'b0;
        end
        if (wr_i) begin
            r_next.pend = 1'b1;
            r_next.pend_data = wdata_i;
        end
        hw_disable = conn_evt & ~r_reg.conn_sync & r_reg.enabled;
        force_csc = wv[`RHS_PORT_ENABLE_BIT] & ~r_reg.connected;
        if (hw_disable || wv[`RHS_PORT_CONNECTED_BIT]) begin
            r_next.enabled = 1'b0;
        end else if (wv[`RHS_PORT_ENABLE_BIT] && r_reg.connected) begin
            r_next.enabled = 1'b1;
        end
        // global commands arrive already masked per port
        pwr_on = global_on_i | (port_cmd_en_i & wv[`RHS_PORT_POWER_BIT]);
        pwr_off = global_off_i | (port_cmd_en_i & wv[`RHS_PORT_CLEAR_POWER_BIT]);
        if (pwr_off) begin
            r_next.powered = 1'b0;
        end else if (pwr_on) begin
            r_next.powered = 1'b1;
        end
        r_next.conn_change = rhs_pkg::rhs_sticky(r_reg.conn_change, conn_evt | force_csc,
                                                 wv[`RHS_PORT_CONNECT_CHANGE_BIT]);
        r_next.enable_change = rhs_pkg::rhs_sticky(r_reg.enable_change, hw_disable,
                                                   wv[`RHS_PORT_ENABLE_CHANGE_BIT]);
    end

    // ----------------------------------------
    // register
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // status in the low word, change flags in the high word
    always_comb begin
        rdata_o = `RHS_PORT_RESET;
        rdata_o[`RHS_PORT_CONNECTED_BIT] = r_reg.connected;
        rdata_o[`RHS_PORT_ENABLE_BIT] = r_reg.enabled;
        rdata_o[`RHS_PORT_POWER_BIT] = r_reg.powered;
        rdata_o[`RHS_PORT_CONNECT_CHANGE_BIT] = r_reg.conn_change;
        rdata_o[`RHS_PORT_ENABLE_CHANGE_BIT] = r_reg.enable_change;
    end

    assign power_o = r_reg.powered;
    assign conn_change_o = conn_evt;

endmodule

// ---- hdl/rhs_root_hub.sv ----
/*
 * Root hub status register and two port status registers reached by
 * read and write command codes on the processor interface: command decode,
 * global power steering, the overcurrent indicator and its change flag,
 * the wake enable, the resume event and the registered read return.
 * Assumes overcurrent and connect pins are asynchronous; mode, mask, busy
 * and suspend inputs come from logic on CLK_I.
 * Assumes a command is a one-cycle valid pulse and a read is answered once.
 */
`timescale 1ns/10ps
`include "rhs_defines.svh"

module rhs_root_hub (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic [7:0] CMD_I,
    input wire logic CMD_VALID_I,
    input wire logic [31:0] WDATA_I,
    output logic [31:0] RDATA_O,
    output logic RDATA_VALID_O,
    input wire logic PER_PORT_SWITCH_SELECT_I,
    input wire logic [1:0] PER_PORT_POWER_MASK_BITS_I,
    input wire logic PER_PORT_OC_REPORT_I,
    input wire logic GLOBAL_OC_I,
    input wire logic [1:0] PORT_CONNECT_I,
    input wire logic XACT_BUSY_I,
    input wire logic SUSPENDED_I,
    output logic [1:0] PORT_POWERED_O,
    output logic RESUME_SEEN_INTERRUPT_O
);

    rhs_pkg::rhs_hub_t r_reg;
    rhs_pkg::rhs_hub_t r_next;

    logic hub_wr;
    logic hub_rd;
    logic [1:0] port_wr;
    logic [1:0] port_rd;
    logic global_on;
    logic global_off;
    logic oci_now;
    logic [1:0] gate_global;
    logic [1:0] gate_port;
    logic [1:0] conn_change;
    logic [31:0] port_rdata [0:`RHS_NUM_PORTS-1];
    logic [31:0] hub_view;
    logic oc_edge;
    logic oc_clear;
    logic wake_clear;
    logic wake_set;
    logic resume_evt;
    logic [1:0] port_on;
    logic [1:0] port_off;
    logic rd_any;
    logic [31:0] rd_word;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // a code counts only in the cycle its valid is high
    function automatic logic rhs_code_hit(input logic valid, input logic [7:0] code, input logic [7:0] want);
        rhs_code_hit = valid & (code == want);
    endfunction

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    // unknown codes match nothing and are dropped
    always_comb begin
        hub_wr = rhs_code_hit(CMD_VALID_I, CMD_I, `RHS_CMD_HUB_WR);
        hub_rd = rhs_code_hit(CMD_VALID_I, CMD_I, `RHS_CMD_HUB_RD);
        port_wr[0] = rhs_code_hit(CMD_VALID_I, CMD_I, `RHS_CMD_P1_WR);
        port_wr[1] = rhs_code_hit(CMD_VALID_I, CMD_I, `RHS_CMD_P2_WR);
        port_rd[0] = rhs_code_hit(CMD_VALID_I, CMD_I, `RHS_CMD_P1_RD);
        port_rd[1] = rhs_code_hit(CMD_VALID_I, CMD_I, `RHS_CMD_P2_RD);
    end

    // ----------------------------------------
    // global power steering
    // ----------------------------------------
    always_comb begin
        global_on = hub_wr & WDATA_I[`RHS_HUB_SET_POWER_BIT];
        global_off = hub_wr & WDATA_I[`RHS_HUB_CLEAR_POWER_BIT];
        // global mode: every port; per-port mode: unmasked ports only
        gate_global = ~({2{PER_PORT_SWITCH_SELECT_I}} & PER_PORT_POWER_MASK_BITS_I);
        gate_port = {2{PER_PORT_SWITCH_SELECT_I}} & PER_PORT_POWER_MASK_BITS_I;
        // only the two implemented ports see the global commands
        port_on = {2{global_on}} & gate_global;
        port_off = {2{global_off}} & gate_global;
    end

    // ----------------------------------------
    // per-port registers
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `RHS_NUM_PORTS; gi = gi + 1) begin : g_port
            // each port holds its own write until the bus is quiet
            rhs_port_reg u_port (
                .clk_i(CLK_I),
                .rst_b_i(RST_B_I),
                .conn_pin_i(PORT_CONNECT_I[gi]),
                .xact_busy_i(XACT_BUSY_I),
                .wr_i(port_wr[gi]),
                .wdata_i(WDATA_I),
                .global_on_i(port_on[gi]),
                .global_off_i(port_off[gi]),
                .port_cmd_en_i(gate_port[gi]),
                .rdata_o(port_rdata[gi]),
                .power_o(PORT_POWERED_O[gi]),
                .conn_change_o(conn_change[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // hub register view
    // ----------------------------------------
    always_comb begin
        hub_view = `RHS_HUB_RESET;
        hub_view[`RHS_HUB_CLEAR_WAKE_BIT] = 1'b0;
        hub_view[`RHS_HUB_OC_CHANGE_BIT] = r_reg.oc_change;
        hub_view[`RHS_HUB_SET_POWER_BIT] = 1'b0;
        hub_view[`RHS_HUB_WAKE_BIT] = r_reg.wake_en;
        hub_view[`RHS_HUB_OC_BIT] = r_reg.oc_flag;
        hub_view[`RHS_HUB_CLEAR_POWER_BIT] = 1'b0;
    end

    // ----------------------------------------
    // overcurrent indicator
    // ----------------------------------------
    always_comb begin
        // per-port reporting forces the hub indicator low
        oci_now = r_reg.oc_sync & ~PER_PORT_OC_REPORT_I;
        oc_edge = oci_now ^ r_reg.oc_flag;
        oc_clear = hub_wr & WDATA_I[`RHS_HUB_OC_CHANGE_BIT];
    end

    // ----------------------------------------
    // wake enable commands
    // ----------------------------------------
    always_comb begin
        wake_clear = hub_wr & WDATA_I[`RHS_HUB_CLEAR_WAKE_BIT];
        wake_set = hub_wr & WDATA_I[`RHS_HUB_WAKE_BIT];
    end

    // ----------------------------------------
    // resume event
    // ----------------------------------------
    always_comb begin
        // a connect change on either port wakes a suspended controller while wake is enabled
        resume_evt = r_reg.wake_en & SUSPENDED_I & (|conn_change);
    end

    // ----------------------------------------
    // read return select
    // ----------------------------------------
    always_comb begin
        rd_any = hub_rd | port_rd[0] | port_rd[1];
        // zero outside a read so no stale word stands on the bus
        rd_word = 32'h0000_0000;
        if (hub_rd) begin
            rd_word = hub_view;
        end else if (port_rd[0]) begin
            rd_word = port_rdata[0];
        end else if (port_rd[1]) begin
            rd_word = port_rdata[1];
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        r_next = r_reg;
        // two flops before the overcurrent pin is read
        r_next.oc_meta = GLOBAL_OC_I;
        r_next.oc_sync = r_reg.oc_meta;
        r_next.oc_flag = oci_now;
        // a change and a clear in one cycle leave the flag set
        r_next.oc_change = rhs_pkg::rhs_sticky(r_reg.oc_change, oc_edge, oc_clear);
        // clear wins when both wake bits are written in one command
        if (wake_clear) begin
            r_next.wake_en = 1'b0;
        end else if (wake_set) begin
            r_next.wake_en = 1'b1;
        end
        r_next.resume = resume_evt;
        r_next.rvalid = rd_any;
        r_next.rdata = rd_word;
    end

    // ----------------------------------------
    // register
    // ----------------------------------------
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign RDATA_O = r_reg.rdata;
    assign RDATA_VALID_O = r_reg.rvalid;
    assign RESUME_SEEN_INTERRUPT_O = r_reg.resume;

endmodule

// ---- tb/rhs_root_hub_properties.sv ----
/*
 * Port-level checker of the root hub status block.
 * Assumes it is bound to rhs_root_hub and sees only its ports.
 */
`timescale 1ns/10ps

module rhs_root_hub_properties (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic [7:0] CMD_I,
    input wire logic CMD_VALID_I,
    input wire logic [31:0] WDATA_I,
    input wire logic [31:0] RDATA_O,
    input wire logic RDATA_VALID_O,
    input wire logic PER_PORT_SWITCH_SELECT_I,
    input wire logic [1:0] PER_PORT_POWER_MASK_BITS_I,
    input wire logic PER_PORT_OC_REPORT_I,
    input wire logic XACT_BUSY_I,
    input wire logic SUSPENDED_I,
    input wire logic [1:0] PORT_POWERED_O,
    input wire logic RESUME_SEEN_INTERRUPT_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    logic [7:0] last_reg;
    logic rd_cmd;
    logic hub_wr;
    assign rd_cmd = CMD_VALID_I && (CMD_I inside {8'h14, 8'h15, 8'h16});
    assign hub_wr = CMD_VALID_I && CMD_I == 8'h94;
    // last taken code, to know what a read answers
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            last_reg <= 8'h00;
        end else begin
            last_reg <= CMD_VALID_I ? CMD_I : 8'h00;
        end
    end
    a_read_pulse: assert property (rd_cmd |=> RDATA_VALID_O)
        else $error("read code without answer");
    a_no_stray: assert property (!rd_cmd |=> !RDATA_VALID_O)
        else $error("answer without read code");
    a_hub_zeros: assert property (RDATA_VALID_O && last_reg == 8'h14 |-> (RDATA_O & 32'hfffd7ffd) == 32'h0)
        else $error("hub read shows fixed-zero bits set");
    a_port_frame: assert property (RDATA_VALID_O && last_reg inside {8'h15, 8'h16} |-> (RDATA_O & 32'hfffcfefc) == 32'h0)
        else $error("port read outside its fields");
    a_oc_masked: assert property (RDATA_VALID_O && last_reg == 8'h14 && $past(PER_PORT_OC_REPORT_I, 2) |-> !RDATA_O[1])
        else $error("overcurrent shown under per-port reporting");
    a_global_on: assert property (hub_wr && WDATA_I[16] && !WDATA_I[0] && !PER_PORT_SWITCH_SELECT_I
        |-> ##[1:2] PORT_POWERED_O == 2'b11)
        else $error("global power on missed a port");
    a_global_off: assert property (hub_wr && WDATA_I[0] && !PER_PORT_SWITCH_SELECT_I |-> ##[1:2] PORT_POWERED_O == 2'b00)
        else $error("global power off missed a port");
    a_masked_hold: assert property (hub_wr && PER_PORT_SWITCH_SELECT_I && PER_PORT_POWER_MASK_BITS_I == 2'b11
        |=> $stable(PORT_POWERED_O) [*2])
        else $error("masked port followed global power");
    a_defer_busy: assert property (CMD_VALID_I && CMD_I == 8'h95 && XACT_BUSY_I ##1 XACT_BUSY_I
        |=> $stable(PORT_POWERED_O[0]))
        else $error("port write applied during transaction");
    a_resume_susp: assert property (RESUME_SEEN_INTERRUPT_O |-> $past(SUSPENDED_I))
        else $error("resume event outside suspend");
    a_reset_quiet: assert property ($rose(RST_B_I) |-> PORT_POWERED_O == 2'b00 && !RDATA_VALID_O)
        else $error("outputs not zero after reset");
endmodule

bind rhs_root_hub rhs_root_hub_properties u_props (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .CMD_I(CMD_I),
    .CMD_VALID_I(CMD_VALID_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .RDATA_VALID_O(RDATA_VALID_O),
    .PER_PORT_SWITCH_SELECT_I(PER_PORT_SWITCH_SELECT_I), .PER_PORT_POWER_MASK_BITS_I(PER_PORT_POWER_MASK_BITS_I),
    .PER_PORT_OC_REPORT_I(PER_PORT_OC_REPORT_I), .XACT_BUSY_I(XACT_BUSY_I), .SUSPENDED_I(SUSPENDED_I),
    .PORT_POWERED_O(PORT_POWERED_O), .RESUME_SEEN_INTERRUPT_O(RESUME_SEEN_INTERRUPT_O));

// ---- tb/rhs_usb_dev_model.sv ----
/*
 * Devices on the two downstream ports: attach level and bus transactions.
 * Assumes start_i is a one-cycle pulse on clk_i.
 */
`timescale 1ns/10ps

module rhs_usb_dev_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [1:0] attach_i,
    input wire logic start_i,
    output logic [1:0] connect_o,
    output logic busy_o
);
    logic [2:0] left;
    // a transaction holds the bus for six cycles
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            left <= 3'h0;
            connect_o <= 2'h0;
        end else begin
            connect_o <= attach_i;
            if (start_i) begin
                left <= 3'h6;
            end else if (left != 3'h0) begin
                left <= left - 3'h1;
            end
        end
    end
    assign busy_o = (left != 3'h0);
endmodule

// ---- tb/rhs_root_hub_tb.sv ----
/*
 * Self-checking bench of the root hub status block.
 * Assumes rhs_defines.svh is on the include path.
 */
`timescale 1ns/10ps
`include "rhs_defines.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("Error %s exp %h got %h", n, e, g); end end

module rhs_root_hub_tb;
    logic clk = 0, rst_b = 0, cmd_v = 0, sw = 0, ocr = 0, oc = 0, susp = 0, xs = 0, rv, busy, res;
    logic [7:0] cmd = 8'h00, c;
    logic [31:0] wd = 32'h0, rdata, e;
    logic [1:0] mask = 2'h0, att = 2'h0, con, pw;
    int fails = 0, cmp_count = 0, pulses = 0, cyc = 0;
    integer seed = 32'hccb17f77;
    logic [31:0] q[$];

    rhs_root_hub dut (.CLK_I(clk), .RST_B_I(rst_b), .CMD_I(cmd), .CMD_VALID_I(cmd_v), .WDATA_I(wd),
        .RDATA_O(rdata), .RDATA_VALID_O(rv), .PER_PORT_SWITCH_SELECT_I(sw), .PER_PORT_POWER_MASK_BITS_I(mask),
        .PER_PORT_OC_REPORT_I(ocr), .GLOBAL_OC_I(oc), .PORT_CONNECT_I(con), .XACT_BUSY_I(busy),
        .SUSPENDED_I(susp), .PORT_POWERED_O(pw), .RESUME_SEEN_INTERRUPT_O(res));
    rhs_usb_dev_model dev (.clk_i(clk), .rst_b_i(rst_b), .attach_i(att), .start_i(xs), .connect_o(con),
        .busy_o(busy));

    initial forever #12.5 clk = ~clk;

    task automatic test_done;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic op(input logic [7:0] k, input logic [31:0] d);
        @(negedge clk);
        cmd = k;
        wd = d;
        cmd_v = 1;
        @(negedge clk);
        cmd_v = 0;
    endtask
    task automatic rd(input logic [7:0] k, input logic [31:0] x);
        q.push_back(x);
        op(k, 32'h0);
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ----------------------------------------
    // read watcher and hang guard
    // ----------------------------------------
    always @(negedge clk) begin
        if (res === 1'b1) pulses++;
        if (rv === 1'b1 && q.size() == 0) begin
            fails++;
            $display("Error rdata exp none got %h", rdata);
        end else if (rv === 1'b1) begin
            e = q.pop_front();
            `CHK("rdata", e, rdata)
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            $display("Error timeout exp done got hang");
            test_done;
        end
    end

    initial begin
        wt(5);
        rst_b = 1;
        rd(`RHS_CMD_HUB_RD, 32'h0);
        rd(`RHS_CMD_P1_RD, 32'h0);
        rd(`RHS_CMD_P2_RD, 32'h0);
        for (int i = 0; i < 8; i++) begin
            c = $random(seed);
            if (c[6:0] inside {7'h14, 7'h15, 7'h16}) c = 8'h00;
            op(c, $random(seed));
        end
        wt(2);
        `CHK("queue", 0, q.size())
        $display("test codes done");
        op(`RHS_CMD_HUB_WR, 32'h0000_8000);
        rd(`RHS_CMD_HUB_RD, 32'h0000_8000);
        op(`RHS_CMD_HUB_WR, 32'h0);
        rd(`RHS_CMD_HUB_RD, 32'h0000_8000);
        op(`RHS_CMD_HUB_WR, 32'h8000_0000);
        rd(`RHS_CMD_HUB_RD, 32'h0);
        $display("test wake done");
        oc = 1;
        wt(6);
        rd(`RHS_CMD_HUB_RD, 32'h0002_0002);
        op(`RHS_CMD_HUB_WR, 32'h0002_0000);
        rd(`RHS_CMD_HUB_RD, 32'h0000_0002);
        ocr = 1;
        wt(1);
        rd(`RHS_CMD_HUB_RD, 32'h0002_0000);
        ocr = 0;
        oc = 0;
        wt(6);
        rd(`RHS_CMD_HUB_RD, 32'h0002_0000);
        op(`RHS_CMD_HUB_WR, 32'h0002_0000);
        $display("test overcurrent done");
        op(`RHS_CMD_HUB_WR, 32'h0001_0000);
        wt(2);
        `CHK("power", 2'b11, pw)
        rd(`RHS_CMD_P1_RD, 32'h0000_0100);
        op(`RHS_CMD_HUB_WR, 32'h0000_0001);
        wt(2);
        `CHK("power", 2'b00, pw)
        sw = 1;
        mask = 2'b01;
        op(`RHS_CMD_HUB_WR, 32'h0001_0000);
        wt(2);
        `CHK("power", 2'b10, pw)
        op(`RHS_CMD_P1_WR, 32'h0000_0100);
        wt(2);
        `CHK("power", 2'b11, pw)
        xs = 1;
        wt(1);
        xs = 0;
        op(`RHS_CMD_P1_WR, 32'h0000_0200);
        wt(1);
        `CHK("power", 2'b11, pw)
        wt(8);
        `CHK("power", 2'b10, pw)
        mask = 2'b11;
        op(`RHS_CMD_HUB_WR, 32'h0000_0001);
        wt(2);
        `CHK("power", 2'b10, pw)
        op(`RHS_CMD_HUB_WR, 32'h0000_8000);
        rst_b = 0;
        wt(2);
        `CHK("power", 2'b00, pw)
        rst_b = 1;
        rd(`RHS_CMD_HUB_RD, 32'h0);
        $display("test power done");
        op(`RHS_CMD_HUB_WR, 32'h0000_8000);
        susp = 1;
        att = 2'b10;
        wt(10);
        `CHK("resume", 1, pulses)
        rd(`RHS_CMD_P2_RD, 32'h0001_0001);
        op(`RHS_CMD_P2_WR, 32'h0001_0000);
        rd(`RHS_CMD_P2_RD, 32'h0000_0001);
        op(`RHS_CMD_HUB_WR, 32'h8000_0000);
        att = 2'b11;
        wt(10);
        `CHK("resume", 1, pulses)
        rd(`RHS_CMD_P1_RD, 32'h0001_0001);
        op(`RHS_CMD_P1_WR, 32'h0000_0002);
        rd(`RHS_CMD_P1_RD, 32'h0001_0003);
        att = 2'b10;
        wt(6);
        rd(`RHS_CMD_P1_RD, 32'h0003_0000);
        op(`RHS_CMD_P1_WR, 32'h0003_0002);
        rd(`RHS_CMD_P1_RD, 32'h0001_0000);
        wt(3);
        `CHK("queue", 0, q.size())
        $display("test resume done");
        test_done;
    end
endmodule
